/* verilog/block_ram_preload.sv */
// Preloaded 4096-bit block RAM behind an AXI4-Lite slave, with a small
// single-value memory and a start-up register beside it.
// Assumes a well-behaved AXI4-Lite master, one write and one read at once.
`timescale 1ns/1ps
module block_ram_preload #(
  parameter int WIDTH = 1,
  parameter logic [bram_preload_pkg::BRAM_BITS-1:0] PRELOAD = '0,
  parameter logic [bram_preload_pkg::SEG_COUNT-1:0] SEG_GIVEN = '0,
  parameter int SMALL_DEPTH = 32,
  parameter logic [31:0] SMALL_INIT = 32'h0000_0000,
  parameter bit SMALL_IS_ROM = 1'b0,
  parameter bit START_SET = 1'b0
) (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic [bram_preload_pkg::BUS_ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [bram_preload_pkg::BUS_ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import bram_preload_pkg::*;

  localparam int DEPTH = BRAM_BITS / WIDTH;
  localparam int SEG_WORDS = SEG_BITS / WIDTH;
  localparam logic [MEM_ADDR_W-1:0] ADDR_MASK = MEM_ADDR_W'(DEPTH - 1);
  localparam logic [BRAM_BITS-1:0] IMAGE = build_image(PRELOAD, SEG_GIVEN);

  if (WIDTH != 1 && WIDTH != 2 && WIDTH != 4 && WIDTH != 8 &&
      WIDTH != 16) begin : g_bad_width
    $error("block_ram_preload: WIDTH must be 1, 2, 4, 8 or 16");
  end

  typedef struct packed {
    logic [BRAM_BITS-1:0] mem;
    logic fresh;
    logic [MEM_ADDR_W-1:0] addr;
    logic [SMALL_ADDR_W-1:0] small_addr;
    wr_state_e wst;
    logic aw_got;
    logic w_got;
    logic [BUS_ADDR_W-1:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    rd_state_e rst;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic chk;
    logic [MEM_ADDR_W-1:0] chk_addr;
  } state_s;

  state_s s;
  state_s next_s;
  logic small_we;
  logic start_we;
  logic small_rbit;
  logic start_q;
  logic [SMALL_ADDR_W-1:0] small_addr_now;

  // A narrow write must carry the lanes its width occupies
  function automatic logic lanes_ok(input logic [3:0] strb);
    return strb[0] && (WIDTH <= 8 || strb[1]);
  endfunction

  always_comb begin
    logic aw_now;
    logic w_now;
    logic [BUS_ADDR_W-1:0] wa;
    logic [31:0] wd;
    logic [3:0] ws;
    reg_sel_e sel;
    aw_now = 1'b0;
    w_now = 1'b0;
    wa = '0;
    wd = '0;
    ws = '0;
    sel = SEL_NONE;
    next_s = s;
    small_we = 1'b0;
    start_we = 1'b0;
    small_addr_now = s.small_addr;

    case (s.wst)
      W_COLLECT: begin
        aw_now = s.aw_got || AWVALID;
        w_now = s.w_got || WVALID;
        wa = s.aw_got ? s.waddr : AWADDR;
        wd = s.w_got ? s.wdata : WDATA;
        ws = s.w_got ? s.wstrb : WSTRB;
        if (AWVALID && !s.aw_got) begin
          next_s.aw_got = 1'b1;
          next_s.waddr = AWADDR;
        end
        if (WVALID && !s.w_got) begin
          next_s.w_got = 1'b1;
          next_s.wdata = WDATA;
          next_s.wstrb = WSTRB;
        end
        if (aw_now && w_now) begin
          sel = reg_select(wa);
          next_s.bresp = RESP_OKAY;
          case (sel)
            SEL_MEM_ADDR: begin
              if (ws[0] && ws[1]) begin
                next_s.addr = wd[MEM_ADDR_W-1:0] & ADDR_MASK;
              end
            end
            SEL_MEM_DATA: begin
              if (lanes_ok(ws)) begin
                next_s.mem[MEM_ADDR_W'(int'(s.addr) * WIDTH) +: WIDTH] =
                  wd[WIDTH-1:0];
                next_s.fresh = 1'b0;
              end
            end
            SEL_SMALL_ADDR: begin
              if (ws[0]) begin
                next_s.small_addr = wd[SMALL_ADDR_W-1:0];
              end
            end
            SEL_SMALL_DATA: begin
              small_we = ws[0];
            end
            SEL_START_REG: begin
              start_we = ws[0];
            end
            SEL_INFO: begin
              next_s.bresp = RESP_SLVERR;
            end
            default: begin
              next_s.bresp = RESP_SLVERR;
            end
          endcase
          next_s.aw_got = 1'b0;
          next_s.w_got = 1'b0;
          next_s.wst = W_RESP;
        end
      end
      W_RESP: begin
        if (BREADY) begin
          next_s.wst = W_COLLECT;
        end
      end
      default: begin
        next_s.wst = W_COLLECT;
      end
    endcase

    case (s.rst)
      R_IDLE: begin
        if (ARVALID) begin
          sel = reg_select(ARADDR);
          next_s.rdata = '0;
          next_s.rresp = RESP_OKAY;
          next_s.chk = 1'b0;
          next_s.chk_addr = s.addr;
          case (sel)
            SEL_MEM_ADDR: next_s.rdata[MEM_ADDR_W-1:0] = s.addr;
            SEL_MEM_DATA: begin
              // Reads see the stored word; preload until first write
              next_s.rdata[15:0] = word_at(s.mem, s.addr, WIDTH);
              next_s.chk = s.fresh;
            end
            SEL_SMALL_ADDR: next_s.rdata[SMALL_ADDR_W-1:0] = s.small_addr;
            SEL_SMALL_DATA: next_s.rdata[0] = small_rbit;
            SEL_START_REG: next_s.rdata[0] = start_q;
            SEL_INFO: begin
              next_s.rdata[4:0] = 5'(WIDTH);
              next_s.rdata[INFO_FRESH_BIT] = s.fresh;
            end
            default: next_s.rresp = RESP_SLVERR;
          endcase
          next_s.rst = R_DATA;
        end
      end
      R_DATA: begin
        if (RREADY) begin
          next_s.rst = R_IDLE;
        end
      end
      default: begin
        next_s.rst = R_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      s.mem <= IMAGE;
      s.fresh <= 1'b1;
      s.addr <= '0;
      s.small_addr <= '0;
      s.wst <= W_COLLECT;
      s.aw_got <= 1'b0;
      s.w_got <= 1'b0;
      s.waddr <= '0;
      s.wdata <= '0;
      s.wstrb <= '0;
      s.bresp <= RESP_OKAY;
      s.rst <= R_IDLE;
      s.rdata <= '0;
      s.rresp <= RESP_OKAY;
      s.chk <= 1'b0;
      s.chk_addr <= '0;
    end else begin
      s <= next_s;
    end
  end

  small_preload_mem #(
    .DEPTH(SMALL_DEPTH),
    .INIT_VALUE(SMALL_INIT),
    .IS_ROM(SMALL_IS_ROM),
    .START_SET(START_SET)
  ) u_small (
    .clk(CLK),
    .rstn(RSTN),
    .we(small_we),
    .addr(small_addr_now),
    .wbit(s.w_got ? s.wdata[0] : WDATA[0]),
    .rbit(small_rbit),
    .start_we(start_we),
    .start_d(s.w_got ? s.wdata[0] : WDATA[0]),
    .start_q(start_q)
  );

  assign AWREADY = (s.wst == W_COLLECT) && !s.aw_got;
  assign WREADY = (s.wst == W_COLLECT) && !s.w_got;
  assign BVALID = (s.wst == W_RESP);
  assign BRESP = s.bresp;
  assign ARREADY = (s.rst == R_IDLE);
  assign RVALID = (s.rst == R_DATA);
  assign RDATA = s.rdata;
  assign RRESP = s.rresp;

  AST_READ_PRELOAD: assert property (@(posedge CLK) disable iff (!RSTN)
    RVALID && s.chk |-> RDATA[15:0] == word_at(IMAGE, s.chk_addr, WIDTH))
    else $error("untouched word differs from its preload");

  AST_SEG_MAP: assert property (@(posedge CLK) disable iff (!RSTN)
    RVALID && s.chk |-> RDATA[WIDTH-1:0] ==
      IMAGE[(int'(s.chk_addr) / SEG_WORDS) * SEG_BITS +
            (int'(s.chk_addr) % SEG_WORDS) * WIDTH +: WIDTH])
    else $error("word not taken from its segment range");

  AST_SEG_UNPACK: assert property (@(posedge CLK) disable iff (!RSTN)
    RVALID && s.chk && (int'(s.chk_addr) % SEG_WORDS == 0) |->
      RDATA[WIDTH-1:0] ==
      PRELOAD[(int'(s.chk_addr) / SEG_WORDS) * SEG_BITS +: WIDTH] ||
      !SEG_GIVEN[int'(s.chk_addr) / SEG_WORDS])
    else $error("segment start word is not its low bits");

  AST_UNGIVEN_ZERO: assert property (@(posedge CLK) disable iff (!RSTN)
    RVALID && s.chk && !SEG_GIVEN[int'(s.chk_addr) / SEG_WORDS]
      |-> RDATA == 32'h0000_0000)
    else $error("segment without a string is not zero");

  AST_NO_PRELOAD: assert property (@(posedge CLK) disable iff (!RSTN)
    RVALID && s.chk && (SEG_GIVEN == '0) |-> RDATA == 32'h0000_0000)
    else $error("unloaded block RAM is not zero");

  AST_WIDTH: assert property (@(posedge CLK) disable iff (!RSTN)
    RVALID && s.chk |-> (RDATA >> WIDTH) == 32'h0000_0000)
    else $error("word wider than the chosen width");

  AST_BVALID_HOLD: assert property (@(posedge CLK) disable iff (!RSTN)
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");

  AST_RVALID_HOLD: assert property (@(posedge CLK) disable iff (!RSTN)
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before taken");

  AST_WR_ANSWER: assert property (@(posedge CLK) disable iff (!RSTN)
    AWVALID && AWREADY && WVALID && WREADY |=> BVALID)
    else $error("write answer not given one cycle after take");

  AST_RD_ANSWER: assert property (@(posedge CLK) disable iff (!RSTN)
    ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read answer not given one cycle after take");

  AST_BUSY_NO_TAKE: assert property (@(posedge CLK) disable iff (!RSTN)
    BVALID |-> !AWREADY && !WREADY)
    else $error("write channel open while answer pending");

  AST_UNMAPPED_RD: assert property (@(posedge CLK) disable iff (!RSTN)
    ARVALID && ARREADY && reg_select(ARADDR) == SEL_NONE
      |=> RRESP == RESP_SLVERR)
    else $error("unmapped read not refused");

  AST_MEM_UPPER: assert property (@(posedge CLK) disable iff (!RSTN)
    ARVALID && ARREADY && ARADDR == OFS_MEM_DATA
      |=> RRESP == RESP_OKAY && RDATA[31:16] == 16'h0000)
    else $error("block RAM word carries upper bits");

endmodule

/* verilog/bram_preload_pkg.sv */
// Shared constants, register map and image helpers for the block RAM
// preload block. Assumes a 32-bit AXI4-Lite master and a 50 MHz clock.
package bram_preload_pkg;

  localparam int BRAM_BITS = 4096;
  localparam int SEG_BITS = 256;
  localparam int SEG_COUNT = 16;
  localparam int SEG_DIGITS = 64;
  localparam int SMALL_MAX_DEPTH = 32;
  localparam int MEM_ADDR_W = 12;
  localparam int SMALL_ADDR_W = 5;
  localparam int BUS_ADDR_W = 8;

  localparam logic [7:0] OFS_MEM_ADDR = 8'h00;
  localparam logic [7:0] OFS_MEM_DATA = 8'h04;
  localparam logic [7:0] OFS_SMALL_ADDR = 8'h08;
  localparam logic [7:0] OFS_SMALL_DATA = 8'h0C;
  localparam logic [7:0] OFS_START_REG = 8'h10;
  localparam logic [7:0] OFS_INFO = 8'h14;
  localparam int INFO_FRESH_BIT = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    W_COLLECT = 2'h0,
    W_RESP = 2'h1
  } wr_state_e;

  typedef enum logic {
    R_IDLE = 1'h0,
    R_DATA = 1'h1
  } rd_state_e;

  typedef enum logic [2:0] {
    SEL_MEM_ADDR,
    SEL_MEM_DATA,
    SEL_SMALL_ADDR,
    SEL_SMALL_DATA,
    SEL_START_REG,
    SEL_INFO,
    SEL_NONE
  } reg_sel_e;

  function automatic reg_sel_e reg_select(input logic [7:0] a);
    if (a == OFS_MEM_ADDR) begin
      return SEL_MEM_ADDR;
    end else if (a == OFS_MEM_DATA) begin
      return SEL_MEM_DATA;
    end else if (a == OFS_SMALL_ADDR) begin
      return SEL_SMALL_ADDR;
    end else if (a == OFS_SMALL_DATA) begin
      return SEL_SMALL_DATA;
    end else if (a == OFS_START_REG) begin
      return SEL_START_REG;
    end else if (a == OFS_INFO) begin
      return SEL_INFO;
    end else begin
      return SEL_NONE;
    end
  endfunction

  // Segment strings arrive as 256-bit values, right-most digit in bit 0,
  // so a short string is already zero-extended on its top side
  function automatic logic [BRAM_BITS-1:0] build_image(
    input logic [BRAM_BITS-1:0] pre,
    input logic [SEG_COUNT-1:0] given
  );
    logic [BRAM_BITS-1:0] img;
    img = '0;
    for (int k = 0; k < SEG_COUNT; k++) begin
      if (given[k]) begin
        // Whole-segment copy keeps a short string's zero top bits
        img[k*SEG_BITS +: SEG_BITS] =
          pre[k*SEG_BITS +: SEG_BITS];
      end
    end
    return img;
  endfunction

  // Flat word pick: address a of width w sits at bits a*w upward
  function automatic logic [15:0] word_at(
    input logic [BRAM_BITS-1:0] img,
    input logic [MEM_ADDR_W-1:0] a,
    input int w
  );
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      if (i < w) begin
        r[i] = img[(int'(a) * w + i) % BRAM_BITS];
      end
    end
    return r;
  endfunction

endpackage

/* verilog/small_preload_mem.sv */
// One-bit wide small RAM or ROM with a single-value preload, plus one
// start-up register. Assumes writes come from the bus slave above it.
`timescale 1ns/1ps
module small_preload_mem #(
  parameter int DEPTH = 32,
  parameter logic [31:0] INIT_VALUE = 32'h0000_0000,
  parameter bit IS_ROM = 1'b0,
  parameter bit START_SET = 1'b0
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic we,
  input wire logic [bram_preload_pkg::SMALL_ADDR_W-1:0] addr,
  input wire logic wbit,
  output logic rbit,
  input wire logic start_we,
  input wire logic start_d,
  output logic start_q
);
  import bram_preload_pkg::*;

  // Single value form only suits 16 or 32 locations of one bit
  if (DEPTH != 16 && DEPTH != SMALL_MAX_DEPTH) begin : g_bad_depth
    $error("small_preload_mem: DEPTH must be 16 or 32");
  end

  typedef struct packed {
    logic [DEPTH-1:0] mem;
    logic start;
    logic start_fresh;
    logic fresh;
  } small_s;

  small_s s;
  small_s next_s;

  always_comb begin
    next_s = s;
    if (we && !IS_ROM) begin
      next_s.mem[addr % DEPTH] = wbit;
      next_s.fresh = 1'b0;
    end
    if (start_we) begin
      next_s.start = start_d;
      next_s.start_fresh = 1'b0;
    end
  end

  // Value bit i is the contents of address i
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s.mem <= INIT_VALUE[DEPTH-1:0];
      s.start <= START_SET;
      s.start_fresh <= 1'b1;
      s.fresh <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rbit = s.mem[addr % DEPTH];
  assign start_q = s.start;

  AST_SMALL_LSB: assert property (@(posedge clk) disable iff (!rstn)
    s.fresh |-> rbit == INIT_VALUE[addr % DEPTH])
    else $error("small memory bit differs from preload value");

  AST_STARTUP: assert property (@(posedge clk) disable iff (!rstn)
    s.start_fresh |-> start_q == START_SET)
    else $error("start-up register not at its chosen state");

endmodule

/* tb/tb_block_ram_preload.sv */
// Self-checking bench for the preloaded block RAM, small memory and
// start-up register. Assumes only AXI4-Lite; a cycle ceiling ends any hang.
`timescale 1ns/1ps
module tb_block_ram_preload;
  import bram_preload_pkg::*;
  localparam int W = 4;
  localparam int DEPTH = BRAM_BITS / W;
  localparam logic [15:0] GIVEN = 16'h9003;
  localparam logic [31:0] SINIT = 32'hABAC1234;
  localparam int LIMIT = 40000;
  localparam logic [3:0] EX [6] = '{4'h7, 4'hE, 4'hD, 4'hC, 4'hB, 4'h0};

  // Segment 2 carries a value but is not marked given, so it must read zero
  function automatic logic [BRAM_BITS-1:0] make_pre();
    logic [BRAM_BITS-1:0] p;
    p = '0;
    p[0 +: 256] = 256'h0123456789ABCDEFFEDCBA9876543210;
    p[256 +: 256] = {8{32'hA5A55A5A}};
    p[512 +: 256] = 256'hDEAD;
    p[3072 +: 256] = 256'hBCDE7;
    p[3840 +: 256] = {32'h80000001, 224'h0};
    return p;
  endfunction
  localparam logic [BRAM_BITS-1:0] PRE = make_pre();

  logic CLK, RSTN;
  logic [7:0] AWADDR, ARADDR;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0] WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP;
  int failures, tests_run, cycles;
  logic [3:0] mdl [DEPTH];

  block_ram_preload #(.WIDTH(W), .PRELOAD(PRE), .SEG_GIVEN(GIVEN),
    .SMALL_DEPTH(32), .SMALL_INIT(SINIT), .SMALL_IS_ROM(1'b0),
    .START_SET(1'b1)) u_block_ram_preload (
    .CLK(CLK), .RSTN(RSTN), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY)
  );

  always #10 CLK = ~CLK;

  // Word a lies in segment a*W/256, lowest word in the segment's low bits
  function automatic logic [31:0] exp_pre(input int a);
    int k;
    int b;
    k = (a * W) / SEG_BITS;
    b = (a * W) % SEG_BITS;
    if (!GIVEN[k]) begin
      return 32'h0;
    end
    return 32'(PRE[k*SEG_BITS + b +: W]);
  endfunction

  task check(input string what, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask

  task finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Readies are settled at the falling edge; the handshake is the next rise
  task axi_write(input logic [7:0] a, input logic [31:0] d,
                 output logic [1:0] r);
    logic awt, wt, bt, bv;
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'($urandom_range(1));
    bt = 1'b0;
    while (!bt) begin
      @(negedge CLK);
      awt = AWVALID && AWREADY;
      wt = WVALID && WREADY;
      bt = BVALID && BREADY;
      bv = BVALID;
      r = BRESP;
      @(posedge CLK);
      AWVALID <= AWVALID && !awt;
      WVALID <= WVALID && !wt;
      BREADY <= !bt && (BREADY || bv);
    end
  endtask

  task axi_read(input logic [7:0] a, output logic [31:0] d,
                output logic [1:0] r);
    logic art, rt, rv;
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'($urandom_range(1));
    rt = 1'b0;
    while (!rt) begin
      @(negedge CLK);
      art = ARVALID && ARREADY;
      rt = RVALID && RREADY;
      rv = RVALID;
      d = RDATA;
      r = RRESP;
      @(posedge CLK);
      ARVALID <= ARVALID && !art;
      RREADY <= !rt && (RREADY || rv);
    end
  endtask

  task mem_chk(input int a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_write(OFS_MEM_ADDR, 32'(a), r);
    axi_read(OFS_MEM_DATA, d, r);
    check("mem_data", e, d);
  endtask

  task do_reset();
    RSTN <= 1'b0;
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
  endtask

  always @(posedge CLK) begin
    cycles++;
    if (cycles >= LIMIT) begin
      failures++;
      finish_test();
    end
  end

  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int a;
    CLK = 1'b0;
    RSTN = 1'b0;
    AWADDR = 8'h00;
    ARADDR = 8'h00;
    AWVALID = 1'b0;
    WVALID = 1'b0;
    BREADY = 1'b0;
    ARVALID = 1'b0;
    RREADY = 1'b0;
    WDATA = 32'h0;
    WSTRB = 4'h0;
    failures = 0;
    tests_run = 0;
    cycles = 0;
    void'($urandom(32'hBEC534B9));
    repeat (3) @(posedge CLK);
    RSTN <= 1'b1;
    axi_read(OFS_INFO, d, r);
    check("info", 32'h104, d);
    axi_read(OFS_START_REG, d, r);
    check("start_reg", 32'h1, d);
    for (a = 0; a < DEPTH; a++) begin
      mem_chk(a, exp_pre(a));
    end
    for (a = 0; a < 6; a++) begin
      mem_chk(768 + a, 32'(EX[a]));
    end
    mem_chk(DEPTH - 1, 32'h8);
    for (a = 0; a < 32; a++) begin
      axi_write(OFS_SMALL_ADDR, 32'(a), r);
      axi_read(OFS_SMALL_DATA, d, r);
      check("small_data", 32'(SINIT[a]), d);
    end
    axi_write(OFS_SMALL_DATA, 32'(!SINIT[31]), r);
    axi_read(OFS_SMALL_DATA, d, r);
    check("small_wr", 32'(!SINIT[31]), d);
    axi_read(8'h40, d, r);
    check("unmapped_rresp", 32'(RESP_SLVERR), 32'(r));
    axi_write(8'h40, 32'hFFFFFFFF, r);
    check("unmapped_bresp", 32'(RESP_SLVERR), 32'(r));
    axi_write(OFS_INFO, 32'h0, r);
    check("info_bresp", 32'(RESP_SLVERR), 32'(r));
    for (a = 0; a < DEPTH; a++) begin
      mdl[a] = 4'(exp_pre(a));
    end
    repeat (400) begin
      a = int'($urandom_range(DEPTH - 1));
      if ($urandom_range(1) == 1) begin
        d = $urandom;
        axi_write(OFS_MEM_ADDR, 32'(a), r);
        axi_write(OFS_MEM_DATA, d, r);
        mdl[a] = d[3:0];
      end else begin
        mem_chk(a, 32'(mdl[a]));
      end
    end
    axi_write(OFS_START_REG, 32'h0, r);
    axi_read(OFS_START_REG, d, r);
    check("start_reg_wr", 32'h0, d);
    @(posedge CLK);
    do_reset();
    axi_read(OFS_START_REG, d, r);
    check("start_reg_rst", 32'h1, d);
    for (a = 0; a < DEPTH; a += 37) begin
      mem_chk(a, exp_pre(a));
    end
    finish_test();
  end
endmodule
